/* verilog/anp_pkg.sv */
// Package for the next page register pair: offsets, fields, reset values.
// Assumes a 16-bit management register space addressed by 5-bit offsets.
package anp_pkg;
  localparam int          REG_AW          = 5;
  localparam logic [4:0]  OFF_EXPANSION   = 5'h06;
  localparam logic [4:0]  OFF_LOCAL_NP    = 5'h07;
  localparam logic [4:0]  OFF_PARTNER_NP  = 5'h08;
  localparam int          BIT_NP          = 15;
  localparam int          BIT_ACK         = 14;
  localparam int          BIT_MP          = 13;
  localparam int          BIT_ACK2        = 12;
  localparam int          BIT_TOGGLE      = 11;
  localparam int          CODE_W          = 11;
  localparam int          BIT_PAGE_RX     = 1;
  localparam int          BIT_LOCAL_NP_OK = 2;
  localparam logic [15:0] LOCAL_NP_RESET  = 16'h2001;
  localparam logic [15:0] PARTNER_RESET   = 16'h0000;
  localparam logic [15:0] LOCAL_NP_WMASK  = 16'hb7ff;
endpackage

/* verilog/anp_toggle.sv */
// Toggle tracker: holds the toggle bit of the next page to be sent.
// Assumes a one-cycle pulse per completed link code word exchange.
`timescale 1ns/1ps
`default_nettype none
module anp_toggle
  import anp_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  input  wire logic i_exchanged,
  input  wire logic i_sent_toggle,
  output logic      o_toggle
);
  typedef struct packed {
    logic toggle;
  } anp_tog_t;
  anp_tog_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (i_exchanged) begin
      st_d.toggle = ~i_sent_toggle;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_toggle = st_q.toggle;

  toggle_flip_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_exchanged |=> o_toggle == !$past(i_sent_toggle))
    else $error("toggle not inverted after exchange");
endmodule
`default_nettype wire

/* verilog/anp_regs.sv */
// Next page register pair with the page received flag of the expansion register.
// Assumes the management port gives one-cycle read and write strobes.
// Contract
// - Message page flag in transmit register: clear unformatted, set message; writable.
// - Bit 12 comply acknowledge: 0 cannot comply, 1 will comply; writable.
// - Transmitted toggle bit is inverse of previously exchanged toggle.
// - Bits 10-0 are the writable code; message code when bit 13 set.
// - Code field resets to 0x1, the null page.
// - Partner register bit 15 shows partner next page request.
// - Partner register bit 14 shows partner acknowledge.
// - Partner register bit 13 shows received page type.
// - Partner register at offset 0x8, reads zero after reset.
// - Page received flag set on new page arrival, cleared by reading the expansion register.
`timescale 1ns/1ps
`default_nettype none
module anp_regs
  import anp_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset_n,
  input  wire logic [REG_AW-1:0] i_reg_addr,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [15:0]       i_reg_wdata,
  output logic      [15:0]       o_reg_rdata,
  output logic                   o_reg_hit,
  input  wire logic              i_page_rx_valid,
  input  wire logic [15:0]       i_page_rx_word,
  input  wire logic              i_page_tx_done,
  output logic      [15:0]       o_page_tx_word,
  output logic                   o_page_rx_flag
);
  typedef struct packed {
    logic [15:0] local_np;
    logic [15:0] partner_np;
    logic        page_rx;
    logic [15:0] rdata;
    logic        hit;
    logic [15:0] tx_word;
  } anp_regs_t;
  anp_regs_t st_q, st_d;
  logic      toggle;

  function automatic logic [15:0] read_mux(input logic [REG_AW-1:0] a,
                                           input logic [15:0] lnp,
                                           input logic [15:0] pnp,
                                           input logic        prx);
    logic [15:0] r;
    r = '0;
    case (a)
      OFF_LOCAL_NP:   r = lnp;
      OFF_PARTNER_NP: r = pnp;
      OFF_EXPANSION: begin
        r[BIT_PAGE_RX]     = prx;
        r[BIT_LOCAL_NP_OK] = 1'b1;
      end
      default:        r = '0;
    endcase
    return r;
  endfunction

  function automatic logic is_mapped(input logic [REG_AW-1:0] a);
    return (a == OFF_LOCAL_NP) || (a == OFF_PARTNER_NP) || (a == OFF_EXPANSION);
  endfunction

  anp_toggle u_toggle (
    .i_sys_clk     (i_sys_clk),
    .i_reset_n     (i_reset_n),
    .i_exchanged   (i_page_tx_done),
    .i_sent_toggle (st_q.tx_word[BIT_TOGGLE]),
    .o_toggle      (toggle)
  );

  always_comb begin
    st_d = st_q;
    st_d.hit = 1'b0;
    if (i_reg_wr && i_reg_addr == OFF_LOCAL_NP) begin
      // Toggle and reserved bit 14 are not writable
      st_d.local_np = i_reg_wdata & LOCAL_NP_WMASK;
    end
    if (i_reg_rd) begin
      st_d.rdata = read_mux(i_reg_addr, {st_q.local_np[BIT_NP:BIT_ACK2], toggle,
                            st_q.local_np[CODE_W-1:0]}, st_q.partner_np, st_q.page_rx);
      st_d.hit = is_mapped(i_reg_addr);
      // Reading the expansion register clears the latched flag
      if (i_reg_addr == OFF_EXPANSION) begin
        st_d.page_rx = 1'b0;
      end
    end
    if (i_page_rx_valid) begin
      st_d.partner_np = i_page_rx_word;
      st_d.page_rx = 1'b1;
    end
    // Toggle comes from the tracker, never from the stored copy
    st_d.tx_word = {st_q.local_np[BIT_NP:BIT_ACK2], toggle,
                    st_q.local_np[CODE_W-1:0]};
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q.local_np   <= LOCAL_NP_RESET;
      st_q.partner_np <= PARTNER_RESET;
      st_q.page_rx    <= 1'b0;
      st_q.rdata      <= '0;
      st_q.hit        <= 1'b0;
      st_q.tx_word    <= LOCAL_NP_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_reg_rdata    = st_q.rdata;
  assign o_reg_hit      = st_q.hit;
  assign o_page_tx_word = st_q.tx_word;
  assign o_page_rx_flag = st_q.page_rx;

  sequence s_partner_page;
    i_page_rx_valid ##1 1'b1;
  endsequence

  partner_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_page_rx_valid |=> st_q.partner_np == $past(i_page_rx_word))
    else $error("partner register not loaded");
  partner_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_reg_rd && i_reg_addr == OFF_PARTNER_NP) |=> o_reg_rdata == $past(st_q.partner_np))
    else $error("partner read wrong");
  page_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_partner_page |-> o_page_rx_flag)
    else $error("page received flag not set");
  np_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_page_rx_valid |=> st_q.partner_np[BIT_NP] == $past(i_page_rx_word[BIT_NP]))
    else $error("partner next page bit wrong");
  ack_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_page_rx_valid |=> st_q.partner_np[BIT_ACK] == $past(i_page_rx_word[BIT_ACK]))
    else $error("partner acknowledge bit wrong");
  mp_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_page_rx_valid |=> st_q.partner_np[BIT_MP] == $past(i_page_rx_word[BIT_MP]))
    else $error("partner page type wrong");
  local_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_reg_wr && i_reg_addr == OFF_LOCAL_NP) |=>
      st_q.local_np[BIT_MP:0] == {$past(i_reg_wdata[BIT_MP:BIT_ACK2]), 1'b0,
                                   $past(i_reg_wdata[CODE_W-1:0])})
    else $error("local next page write lost");
  tx_word_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    ##1 o_page_tx_word[CODE_W-1:0] == $past(st_q.local_np[CODE_W-1:0]))
    else $error("transmit code not current");
  tx_toggle_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_page_tx_done |=> ##1 o_page_tx_word[BIT_TOGGLE] == !$past(o_page_tx_word[BIT_TOGGLE], 2))
    else $error("transmit toggle not inverted");

  // Transmit word follows the stored fields one cycle late
  tx_np_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    ##1 o_page_tx_word[BIT_NP] == $past(st_q.local_np[BIT_NP]))
    else $error("transmit next page bit not current");
  tx_mp_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    ##1 o_page_tx_word[BIT_MP] == $past(st_q.local_np[BIT_MP]))
    else $error("transmit page type not current");
  tx_ack2_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    ##1 o_page_tx_word[BIT_ACK2] == $past(st_q.local_np[BIT_ACK2]))
    else $error("transmit comply bit not current");
  tx_toggle_src_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    ##1 o_page_tx_word[BIT_TOGGLE] == $past(toggle))
    else $error("transmit toggle not from tracker");
  toggle_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !i_page_tx_done |=> $stable(toggle))
    else $error("toggle moved without exchange");

  // Stored registers change only through their own paths
  local_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !(i_reg_wr && i_reg_addr == OFF_LOCAL_NP) |=> $stable(st_q.local_np))
    else $error("local register changed without write");
  reserved_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    st_q.local_np[BIT_ACK] == 1'b0)
    else $error("reserved local bit set");
  partner_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !i_page_rx_valid |=> $stable(st_q.partner_np))
    else $error("partner register changed without page");
  partner_ro_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_reg_wr && i_reg_addr == OFF_PARTNER_NP && !i_page_rx_valid) |=>
      $stable(st_q.partner_np))
    else $error("partner register took a write");
  partner_code_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_page_rx_valid |=> st_q.partner_np[CODE_W-1:0] == $past(i_page_rx_word[CODE_W-1:0]))
    else $error("partner code not loaded");

  // Read port: answer one cycle after the strobe, held until the next read
  local_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_reg_rd && i_reg_addr == OFF_LOCAL_NP) |=>
      o_reg_rdata == {$past(st_q.local_np[BIT_NP:BIT_ACK2]), $past(toggle),
                      $past(st_q.local_np[CODE_W-1:0])})
    else $error("local read wrong");
  exp_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_reg_rd && i_reg_addr == OFF_EXPANSION) |=>
      o_reg_rdata[BIT_LOCAL_NP_OK] && o_reg_rdata[BIT_PAGE_RX] == $past(st_q.page_rx))
    else $error("expansion read wrong");
  hit_mapped_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_reg_rd && is_mapped(i_reg_addr)) |=> o_reg_hit)
    else $error("mapped read not acknowledged");
  hit_unmapped_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_reg_rd && !is_mapped(i_reg_addr)) |=> !o_reg_hit && o_reg_rdata == PARTNER_RESET)
    else $error("unmapped read answered");
  hit_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !i_reg_rd |=> !o_reg_hit)
    else $error("hit without read");
  rdata_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without read");

  // Page received flag: arrival beats a read clear in the same cycle
  flag_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_reg_rd && i_reg_addr == OFF_EXPANSION && !i_page_rx_valid) |=> !o_page_rx_flag)
    else $error("page received flag not cleared");
  flag_win_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_reg_rd && i_reg_addr == OFF_EXPANSION && i_page_rx_valid) |=> o_page_rx_flag)
    else $error("page arrival lost to read clear");
  flag_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (!i_page_rx_valid && !(i_reg_rd && i_reg_addr == OFF_EXPANSION)) |=>
      o_page_rx_flag == $past(o_page_rx_flag))
    else $error("page received flag moved");
endmodule
`default_nettype wire

/* sim/anp_partner.sv */
// Link partner model: presents received pages and closes exchanges on command.
// Assumes the bench raises one-cycle commands between clock edges.
`timescale 1ns/1ps
`default_nettype none
module anp_partner (
  input  wire logic        i_sys_clk,
  input  wire logic        i_send,
  input  wire logic        i_finish,
  input  wire logic [15:0] i_word,
  input  wire logic [15:0] i_tx_word,
  output logic             o_page_rx_valid,
  output logic      [15:0] o_page_rx_word,
  output logic             o_page_tx_done,
  output logic      [15:0] o_seen
);
  assign o_page_rx_valid = i_send;
  // Word is not held once invalid, so a late capture shows up
  assign o_page_rx_word  = i_send ? i_word : ~i_word;
  assign o_page_tx_done  = i_finish;
  initial o_seen = 16'h0000;
  always @(posedge i_sys_clk) begin
    if (o_page_tx_done) begin
      o_seen <= i_tx_word;
    end
  end
endmodule
`default_nettype wire

/* sim/tb.sv */
// Testbench: register access and partner page traffic for the next page pair.
// Assumes reads answer within three cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import anp_pkg::*;
  logic        clk = 0, rst_n = 0, wr = 0, rd_s = 0, send = 0, fin = 0;
  logic [4:0]  addr = 0;
  logic [15:0] wdata = 0, pword = 0, rdata, txw, rxw, seen;
  logic        hit, rxv, txd, flag;
  int          n_mismatch = 0, tests_run = 0;
  always #10 clk = ~clk;
  anp_partner part_u (.i_sys_clk(clk), .i_send(send), .i_finish(fin), .i_word(pword),
    .i_tx_word(txw), .o_page_rx_valid(rxv), .o_page_rx_word(rxw), .o_page_tx_done(txd),
    .o_seen(seen));
  anp_regs dut_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd_s), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_hit(hit),
    .i_page_rx_valid(rxv), .i_page_rx_word(rxw), .i_page_tx_done(txd),
    .o_page_tx_word(txw), .o_page_rx_flag(flag));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk) wr = 0;
  endtask
  // Unmapped reads never raise hit; the wait for hit is capped at three cycles
  task automatic rd_chk(input logic [4:0] a, input logic h, input logic [15:0] e,
                        input logic [15:0] m);
    addr = a;
    rd_s = 1;
    @(negedge clk) rd_s = 0;
    for (int i = 0; i < 3 && hit !== 1'b1; i++) @(negedge clk);
    chk({15'h0, hit === 1'b1}, {15'h0, h});
    if (h && hit !== 1'b1) end_sim();
    chk(rdata & m, e);
    @(negedge clk);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    chk(txw, 16'h2001);
    rd_chk(OFF_LOCAL_NP, 1, 16'h2001, 16'hffff);
    rd_chk(OFF_PARTNER_NP, 1, 16'h0000, 16'hffff);
    rd_chk(OFF_EXPANSION, 1, 16'h0004, 16'hffff);
    rd_chk(5'h1f, 0, 16'h0000, 16'hffff);
    wr_reg(OFF_PARTNER_NP, 16'hffff);
    rd_chk(OFF_PARTNER_NP, 1, 16'h0000, 16'hffff);
    wr_reg(OFF_LOCAL_NP, 16'hffff);
    rd_chk(OFF_LOCAL_NP, 1, 16'hb7ff, 16'hffff);
    wr_reg(OFF_LOCAL_NP, 16'h0000);
    rd_chk(OFF_LOCAL_NP, 1, 16'h0000, 16'hffff);
    wr_reg(OFF_LOCAL_NP, 16'h3555);
    @(negedge clk);
    chk(txw, 16'h3555);
    for (int i = 0; i < 2; i++) begin
      fin = 1;
      @(negedge clk) fin = 0;
      repeat (2) @(negedge clk);
      chk(seen, i ? 16'h3d55 : 16'h3555);
      chk(txw, i ? 16'h3555 : 16'h3d55);
    end
    rd_chk(OFF_LOCAL_NP, 1, 16'h3555, 16'hffff);
    for (int i = 0; i < 8; i++) begin
      pword = {i[2:0], 13'h0abc};
      send = 1;
      @(negedge clk) send = 0;
      @(negedge clk);
      chk({15'h0, flag}, 16'h0001);
      rd_chk(OFF_PARTNER_NP, 1, {i[2:0], 13'h0abc}, 16'hffff);
      rd_chk(OFF_EXPANSION, 1, 16'h0006, 16'hffff);
      chk({15'h0, flag}, 16'h0000);
    end
    // Page arrival and read clear in one cycle: the arrival wins
    pword = 16'h1234;
    addr = OFF_EXPANSION;
    send = 1;
    rd_s = 1;
    @(negedge clk);
    send = 0;
    rd_s = 0;
    chk(rdata, 16'h0004);
    chk({15'h0, flag}, 16'h0001);
    @(negedge clk);
    rd_chk(OFF_PARTNER_NP, 1, 16'h1234, 16'hffff);
    rd_chk(OFF_EXPANSION, 1, 16'h0006, 16'hffff);
    rd_chk(OFF_EXPANSION, 1, 16'h0004, 16'hffff);
    end_sim();
  end
endmodule
`default_nettype wire
